/* vbr_cfg.svh */
// vbr_cfg.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from the design file
`ifndef VBR_CFG_SVH
`define VBR_CFG_SVH
// ------------------------------------------------------------------
// byte addresses on the serial link
// ------------------------------------------------------------------
`define VBR_ADDR_IDX_LO    7'h0a
`define VBR_ADDR_IDX_HI    7'h0b
`define VBR_ADDR_XBUF      7'h0e
`define VBR_ADDR_YBUF      7'h10
`define VBR_ADDR_ZBUF      7'h12
`define VBR_ADDR_XOFS      7'h14
`define VBR_ADDR_YOFS      7'h16
`define VBR_ADDR_GCMD      7'h3e
// ------------------------------------------------------------------
// fields and values
// ------------------------------------------------------------------
`define VBR_GCMD_AUTONULL  0
`define VBR_FRAME_BITS     5'd16
`define VBR_XBUF_FIRST     16'h8000
`define VBR_BUF_RESET      16'h0000
`define VBR_OFS_RESET      16'h0000
`define VBR_TIME_DEPTH     4096
`define VBR_SPEC_DEPTH     2048
`define VBR_NULL_SAMPLES   4096
// ------------------------------------------------------------------
// timing
// ------------------------------------------------------------------
`define VBR_CLK_HZ         25000000
`define VBR_NULL_TIME_MS   16
`define VBR_NULL_CYCLES    ((`VBR_NULL_TIME_MS * `VBR_CLK_HZ) / 1000)
`endif

/* vbr_host.sv */
// vbr_host.sv: serial host model, sixteen-bit mode 3 frames, msb first
// assumes: frame() is called from the bench; clock is the bench clock
`timescale 1ns/100ps
`default_nettype none
module vbr_host (
	input  wire logic   clock,
	output logic        sclk,     // stands high between frames
	output logic        cs_n,
	output logic        din,
	input  wire logic   dout,
	output logic        rx_stb,   // one clock: rx_q holds a finished answer
	output logic [15:0] rx_q
);
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		din = 1'b0;
		rx_stb = 1'b0;
		rx_q = 16'h0000;
	end
	task automatic wait_n(input int n);
		repeat (n) @(negedge clock);
	endtask
	// half period of four clocks gives the 320 ns link clock
	task automatic frame(input logic [15:0] tx);
		@(negedge clock);
		cs_n = 1'b0;
		wait_n(8);
		for (int i = 15; i >= 0; i--) begin
			sclk = 1'b0;
			din = tx[i];
			wait_n(4);
			// mode 3: the answer bit is taken on the rising edge, after the device shifted
			rx_q[i] = dout;
			sclk = 1'b1;
			wait_n(4);
		end
		cs_n = 1'b1;
		// released line shows the inverse so a stale bit cannot pass
		din = ~din;
		rx_stb = 1'b1;
		wait_n(1);
		rx_stb = 1'b0;
		// long gap lets a read-triggered reload land before the next frame
		wait_n(11);
	endtask
endmodule // vbr_host
`default_nettype wire

/* vbr_pkg.sv */
// vbr_pkg.sv: types shared by the readout design
// assumes: nothing beyond the constants header
package vbr_pkg;
	// recording mode field, two bits
	typedef enum logic [1:0] {
		VBR_MODE_MSPEC  = 2'h0,
		VBR_MODE_ASPEC  = 2'h1,
		VBR_MODE_TIME   = 2'h2,
		VBR_MODE_STREAM = 2'h3
	} vbr_mode_e;
endpackage

/* vbr_readout.sv */
// vbr_readout.sv: buffer readout, sample index and offset correction
// assumes: serial link pins come from the host unsynchronised; the sample
// engine delivers words on the 25 MHz clock with a valid/ready handshake
`timescale 1ns/100ps
`default_nettype none
`include "vbr_cfg.svh"

// ------------------------------------------------------------------
// small fifo standing in the sample path
// ------------------------------------------------------------------
module vbr_fifo #(
	parameter int WIDTH = 65,
	parameter int DEPTH = 4
) (
	input  wire logic             clock,
	input  wire logic             arst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];   // storage words
	logic [AW-1:0]    wr_q;            // write slot
	logic [AW-1:0]    rd_q;            // read slot
	logic [AW:0]      cnt_q;           // words held
	logic             push;
	logic             pop;

	assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem_q[rd_q];

	// storage written only, no reset needed on data
	always_ff @(posedge clock) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	// pointers wrap at depth
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // vbr_fifo

module vbr_readout #(
	parameter int NULL_CYCLES = `VBR_NULL_CYCLES   // auto-null time limit
) (
	input  wire logic              clock,
	input  wire logic              arst_n,
	input  wire logic              sclk,        // serial clock pin
	input  wire logic              cs_n,        // chip select pin
	input  wire logic              din,         // serial data in pin
	output logic                   dout,        // serial data out pin
	output logic                   dout_oe_n,   // low while driving dout
	input  wire vbr_pkg::vbr_mode_e rec_mode,   // recording mode field
	input  wire logic              velocity_en, // store velocity words
	input  wire logic              rss_en,      // combined word in z
	input  wire logic              capture_start, // engine starts a capture
	output logic                   capture_busy,
	output logic                   autonull_busy,
	input  wire logic              smp_valid,
	output logic                   smp_ready,
	input  wire logic [15:0]       smp_x,
	input  wire logic [15:0]       smp_y,
	input  wire logic [15:0]       smp_z,
	input  wire logic [15:0]       smp_rss,
	input  wire logic              smp_is_vel,  // word is velocity
	input  wire logic              restore_valid, // saved offsets exist
	input  wire logic [15:0]       restore_x,
	input  wire logic [15:0]       restore_y
);
	import vbr_pkg::*;

	// ------------------------------------------------------------------
	// serial link sampling
	// ------------------------------------------------------------------
	logic [2:0]  sclk_q;    // [0] only feeds [1]
	logic [1:0]  cs_q;
	logic [1:0]  din_q;
	logic        sclk_rise;
	logic        sclk_fall;
	logic        cs_fall;
	logic        cs_rise;
	logic        cs_d;

	// two flops before use; third stage finds edges
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sclk_q <= 3'h7;
			cs_q   <= 2'h3;
			din_q  <= 2'h0;
			cs_d   <= 1'b1;
		end else begin
			sclk_q <= {sclk_q[1:0], sclk};
			cs_q   <= {cs_q[0], cs_n};
			din_q  <= {din_q[0], din};
			cs_d   <= cs_q[1];
		end
	end
	assign sclk_rise = sclk_q[1] & ~sclk_q[2];
	assign sclk_fall = ~sclk_q[1] & sclk_q[2];
	assign cs_fall   = ~cs_q[1] & cs_d;
	assign cs_rise   = cs_q[1] & ~cs_d;

	// ------------------------------------------------------------------
	// register state
	// ------------------------------------------------------------------
	logic [15:0] xbuf_q, ybuf_q, zbuf_q;   // buffer words
	logic [15:0] xofs_q, yofs_q;           // offset corrections
	logic [11:0] idx_q;                    // sample index
	logic [15:0] rx_q;                     // incoming frame
	logic [15:0] tx_q;                     // outgoing frame
	logic [4:0]  bits_q;                   // bits in this frame
	logic [6:0]  rd_addr_q;                // address asked for last frame
	logic        rd_buf_q;                 // next frame reads a buffer
	logic        frame_done;
	logic        wr_frame;
	logic        adv;                      // completed buffer read
	logic        load_req;                 // fetch index from memory
	logic        load_q;                   // fetched word is valid next cycle
	logic        stream;
	logic [11:0] idx_max;
	logic [11:0] idx_d;
	logic        null_cmd;
	logic        restored_q;

	assign stream     = (rec_mode == VBR_MODE_STREAM);
	assign idx_max    = (rec_mode == VBR_MODE_TIME) ? 12'hfff : 12'h7ff;
	assign frame_done = cs_rise & (bits_q == `VBR_FRAME_BITS);
	assign wr_frame   = frame_done & rx_q[15];
	assign adv        = frame_done & rd_buf_q & ~stream;
	assign null_cmd   = wr_frame & (rx_q[14:8] == `VBR_ADDR_GCMD) & rx_q[`VBR_GCMD_AUTONULL];

	// true for either byte of any buffer word
	function automatic logic is_buf(input logic [6:0] a);
		is_buf = ({a[6:1], 1'b0} == `VBR_ADDR_XBUF) | ({a[6:1], 1'b0} == `VBR_ADDR_YBUF) |
			({a[6:1], 1'b0} == `VBR_ADDR_ZBUF);
	endfunction

	// word returned for a read; upper bits of index read zero
	function automatic logic [15:0] rd_word(input logic [6:0] a);
		unique case ({a[6:1], 1'b0})
			`VBR_ADDR_IDX_LO: rd_word = {4'h0, idx_q};
			`VBR_ADDR_XBUF:   rd_word = xbuf_q;
			`VBR_ADDR_YBUF:   rd_word = ybuf_q;
			`VBR_ADDR_ZBUF:   rd_word = zbuf_q;
			`VBR_ADDR_XOFS:   rd_word = xofs_q;
			`VBR_ADDR_YOFS:   rd_word = yofs_q;
			default:          rd_word = 16'h0000;
		endcase
	endfunction

	// ------------------------------------------------------------------
	// frame shifter: sample on rising, shift out on falling edge
	// ------------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rx_q      <= '0;
			tx_q      <= '0;
			bits_q    <= '0;
			rd_addr_q <= '0;
			rd_buf_q  <= 1'b0;
		end else begin
			if (cs_fall) begin
				// answer to last frame's read leaves in this one
				tx_q   <= rd_word(rd_addr_q);
				bits_q <= '0;
			end else if (!cs_q[1] && sclk_rise && bits_q != `VBR_FRAME_BITS) begin
				rx_q   <= {rx_q[14:0], din_q[1]};
				bits_q <= bits_q + 5'd1;
			end else if (!cs_q[1] && sclk_fall && bits_q != 5'd0) begin
				tx_q <= {tx_q[14:0], 1'b0};
			end
			if (frame_done) begin
				// a short frame is ignored; a read frame arms the next answer
				rd_addr_q <= rx_q[14:8];
				rd_buf_q  <= ~rx_q[15] & is_buf(rx_q[14:8]);
			end else if (cs_rise) begin
				rd_buf_q <= 1'b0;
			end
		end
	end
	assign dout      = tx_q[15];
	assign dout_oe_n = cs_q[1];

	// ------------------------------------------------------------------
	// sample path: fifo, memory and capture
	// ------------------------------------------------------------------
	logic [64:0] f_data;
	logic        f_valid;
	logic        f_ready;
	logic [47:0] mem_q [`VBR_TIME_DEPTH];   // x, y, z per index
	logic [47:0] rd_q;
	logic [11:0] wr_q;
	logic        cap_q;
	logic        first_done_q;
	logic        take;
	logic [15:0] x_in, y_in;

	vbr_fifo #(.WIDTH(65), .DEPTH(4)) u_fifo (
		.clock     (clock),
		.arst_n    (arst_n),
		.in_valid  (smp_valid),
		.in_ready  (smp_ready),
		.in_data   ({smp_is_vel, smp_x, smp_y, smp_z, smp_rss}),
		.out_valid (f_valid),
		.out_ready (f_ready),
		.out_data  (f_data)
	);

	// host fetches stall the drain; the end-of-capture fetch is not a stall
	// source, since it is itself caused by a drained word (no loop through take)
	assign f_ready = ~(idx_wr | adv);
	assign take    = f_valid & f_ready & cap_q & (f_data[64] == velocity_en);
	// offsets shift time data only; spectral magnitudes stay unsigned
	assign x_in = (rec_mode == VBR_MODE_TIME) ? f_data[63:48] + xofs_q : f_data[63:48];
	assign y_in = (rec_mode == VBR_MODE_TIME) ? f_data[47:32] + yofs_q : f_data[47:32];

	// write while capturing; the last write (top index) and the fetch of index zero may share an edge
	always_ff @(posedge clock) begin
		if (take) begin
			mem_q[wr_q] <= {x_in, y_in, rss_en ? f_data[15:0] : f_data[31:16]};
		end
		if (load_req) begin
			rd_q <= mem_q[idx_d];
		end
	end

	// capture sequencing; streaming never fills the buffers
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cap_q        <= 1'b0;
			wr_q         <= '0;
			first_done_q <= 1'b0;
		end else begin
			if (capture_start && !stream) begin
				cap_q <= 1'b1;
				wr_q  <= '0;
			end else if (take) begin
				wr_q <= wr_q + 12'd1;
				if (wr_q == idx_max) begin
					cap_q        <= 1'b0;
					first_done_q <= 1'b1;
				end
			end
		end
	end
	assign capture_busy = cap_q;

	// ------------------------------------------------------------------
	// sample index
	// ------------------------------------------------------------------
	logic cap_end;
	logic idx_wr;
	assign cap_end  = take & (wr_q == idx_max);
	assign idx_wr   = wr_frame & ({rx_q[14:9], 1'b0} == `VBR_ADDR_IDX_LO);
	assign load_req = cap_end | idx_wr | adv;

	always_comb begin
		idx_d = idx_q;
		if (cap_end) begin
			idx_d = '0;
		end else if (idx_wr && !rx_q[8]) begin
			idx_d = {idx_q[11:8], rx_q[7:0]};
		end else if (idx_wr) begin
			idx_d = {rx_q[3:0], idx_q[7:0]};
		end else if (adv) begin
			idx_d = (idx_q >= idx_max) ? 12'h000 : idx_q + 12'd1;
		end
		idx_d = idx_d & idx_max;
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			idx_q  <= '0;
			load_q <= 1'b0;
		end else begin
			idx_q  <= idx_d;
			load_q <= load_req;
		end
	end

	// ------------------------------------------------------------------
	// buffer words
	// ------------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			xbuf_q <= `VBR_BUF_RESET;
			ybuf_q <= `VBR_BUF_RESET;
			zbuf_q <= `VBR_BUF_RESET;
		end else begin
			if (capture_start && !stream && !first_done_q) begin
				xbuf_q <= `VBR_XBUF_FIRST;
			end else if (load_q && !stream) begin
				xbuf_q <= rd_q[47:32];
				ybuf_q <= rd_q[31:16];
				zbuf_q <= rd_q[15:0];
			end
		end
	end

	// ------------------------------------------------------------------
	// auto-null accumulation and offset registers
	// ------------------------------------------------------------------
	logic        nul_q;
	logic [12:0] ncnt_q;
	logic [31:0] ntime_q;
	logic [27:0] xsum_q, ysum_q;
	logic        ntake;
	logic        ndone;
	logic [27:0] xneg, yneg;
	assign ntake = nul_q & f_valid & f_ready & ~f_data[64];
	assign ndone = ntake & (ncnt_q == 13'(`VBR_NULL_SAMPLES - 1));
	// offset is minus the mean of raw data (sum over 4096 is a 12-bit shift)
	assign xneg  = 28'(0) - (xsum_q + {{12{f_data[63]}}, f_data[63:48]});
	assign yneg  = 28'(0) - (ysum_q + {{12{f_data[47]}}, f_data[47:32]});

	// accumulate at full rate; give up if the time limit passes
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			nul_q   <= 1'b0;
			ncnt_q  <= '0;
			ntime_q <= '0;
			xsum_q  <= '0;
			ysum_q  <= '0;
		end else if (null_cmd && !nul_q) begin
			nul_q   <= 1'b1;
			ncnt_q  <= '0;
			ntime_q <= '0;
			xsum_q  <= '0;
			ysum_q  <= '0;
		end else if (nul_q) begin
			ntime_q <= ntime_q + 32'd1;
			if (ndone || ntime_q == 32'(NULL_CYCLES - 1)) begin
				nul_q <= 1'b0;
			end
			if (ntake) begin
				ncnt_q <= ncnt_q + 13'd1;
				xsum_q <= xsum_q + {{12{f_data[63]}}, f_data[63:48]};
				ysum_q <= ysum_q + {{12{f_data[47]}}, f_data[47:32]};
			end
		end
	end
	assign autonull_busy = nul_q;

	// restore caught once after reset; host bytes or auto-null later
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			xofs_q     <= `VBR_OFS_RESET;
			yofs_q     <= `VBR_OFS_RESET;
			restored_q <= 1'b0;
		end else begin
			restored_q <= 1'b1;
			if (!restored_q && restore_valid) begin
				xofs_q <= restore_x;
				yofs_q <= restore_y;
			end else if (ndone) begin
				xofs_q <= xneg[27:12];
				yofs_q <= yneg[27:12];
			end else if (wr_frame) begin
				unique case (rx_q[14:8])
					`VBR_ADDR_XOFS:         xofs_q[7:0]  <= rx_q[7:0];
					`VBR_ADDR_XOFS + 7'h01: xofs_q[15:8] <= rx_q[7:0];
					`VBR_ADDR_YOFS:         yofs_q[7:0]  <= rx_q[7:0];
					`VBR_ADDR_YOFS + 7'h01: yofs_q[15:8] <= rx_q[7:0];
					default: ;
				endcase
			end
		end
	end
endmodule // vbr_readout
`default_nettype wire

/* vbr_readout_sva.sv */
// vbr_readout_sva.sv: port-level checks of the readout block
// assumes: bound to vbr_readout, sees its ports only, one clock domain
`timescale 1ns/100ps
`default_nettype none
module vbr_readout_sva #(
	parameter int NULL_CYCLES = 400000   // auto-null time limit
) (
	input wire logic               clock,
	input wire logic               arst_n,
	input wire logic               cs_n,
	input wire logic               dout_oe_n,
	input wire vbr_pkg::vbr_mode_e rec_mode,
	input wire logic               capture_start,
	input wire logic               capture_busy,
	input wire logic               autonull_busy,
	input wire logic               smp_valid,
	input wire logic               smp_ready
);
	import vbr_pkg::*;
	logic [12:0] hs_q;   // words accepted at the input, of either kind, since the last capture start, saturating
	logic [19:0] nb_q;   // cycles spent in the running auto-null
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);
	// ----
	// helper counters
	// ----
	// up to four words may sit in the fifo at start, hence the margin below
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			hs_q <= 13'h0000;
		end else if (capture_start) begin
			hs_q <= 13'h0000;
		end else if (smp_valid && smp_ready && hs_q != 13'h1fff) begin
			hs_q <= hs_q + 13'h0001;
		end
	end
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			nb_q <= 20'h00000;
		end else if (!autonull_busy) begin
			nb_q <= 20'h00000;
		end else begin
			nb_q <= nb_q + 20'h00001;
		end
	end
	// ----
	// properties
	// ----
	AST_RESET_IDLE: assert property ($rose(arst_n) |->
		dout_oe_n && smp_ready && !capture_busy && !autonull_busy)
		else $error("outputs not idle after reset");
	AST_CAP_START: assert property (capture_start && !capture_busy &&
		rec_mode != VBR_MODE_STREAM |=> capture_busy)
		else $error("capture did not start");
	AST_STREAM_IDLE: assert property (capture_start && !capture_busy &&
		rec_mode == VBR_MODE_STREAM |=> !capture_busy)
		else $error("capture started in streaming mode");
	AST_CAP_CAUSE: assert property ($rose(capture_busy) |-> $past(capture_start))
		else $error("capture began without a start pulse");
	AST_TIME_DEPTH: assert property ($fell(capture_busy) &&
		rec_mode == VBR_MODE_TIME |-> hs_q >= 13'h0ffc)
		else $error("time capture ended short of its depth");
	AST_SPEC_DEPTH: assert property ($fell(capture_busy) &&
		rec_mode != VBR_MODE_TIME |-> hs_q >= 13'h07fc)
		else $error("spectral capture ended short of its depth");
	AST_NULL_BOUND: assert property (autonull_busy |-> int'(nb_q) <= NULL_CYCLES)
		else $error("auto-null overran its time limit");
	AST_NULL_CAUSE: assert property ($rose(autonull_busy) |-> cs_n && $past(cs_n, 3))
		else $error("auto-null began outside a finished frame");
	AST_OE_FOLLOW: assert property (dout_oe_n == $past(cs_n, 2))
		else $error("data out enable does not follow chip select");
	cover property ($fell(capture_busy));
	cover property ($fell(autonull_busy));
	cover property (smp_valid && !smp_ready);
endmodule // vbr_readout_sva
bind vbr_readout vbr_readout_sva #(.NULL_CYCLES(NULL_CYCLES)) i_sva (
	.clock(clock), .arst_n(arst_n), .cs_n(cs_n), .dout_oe_n(dout_oe_n), .rec_mode(rec_mode),
	.capture_start(capture_start), .capture_busy(capture_busy),
	.autonull_busy(autonull_busy), .smp_valid(smp_valid), .smp_ready(smp_ready));
`default_nettype wire

/* vbr_readout_tb_top.sv */
// vbr_readout_tb_top.sv: self-checking bench for the readout block
// assumes: host model and checker compiled before this file
`timescale 1ns/100ps
`default_nettype none
module vbr_readout_tb_top;
	import vbr_pkg::*;
	logic        clock, arst_n, sclk, cs_n, din, dout, dout_oe_n, velocity_en, rss_en;
	logic        capture_start, capture_busy, autonull_busy, smp_valid, smp_ready;
	logic        smp_is_vel, restore_valid, rx_stb;
	logic [15:0] smp_x, smp_y, smp_z, smp_rss, restore_x, restore_y, rx_q, ofs_x, ofs_y;
	logic [15:0] mx [4096], my [4096], mz [4096];   // expected buffer words
	logic [16:0] notes [$], pend, nt;               // care bit above the word
	vbr_mode_e   rec_mode;
	int          seed, n_mismatch = 0, check_count = 0;
	initial clock = 1'b0;
	always #20 clock = ~clock;
	vbr_readout #(.NULL_CYCLES(20000)) i_dut (
		.clock(clock), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
		.dout_oe_n(dout_oe_n), .rec_mode(rec_mode), .velocity_en(velocity_en), .rss_en(rss_en),
		.capture_start(capture_start), .capture_busy(capture_busy),
		.autonull_busy(autonull_busy), .smp_valid(smp_valid), .smp_ready(smp_ready),
		.smp_x(smp_x), .smp_y(smp_y), .smp_z(smp_z), .smp_rss(smp_rss),
		.smp_is_vel(smp_is_vel), .restore_valid(restore_valid), .restore_x(restore_x),
		.restore_y(restore_y));
	vbr_host i_host (.clock(clock), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
		.rx_stb(rx_stb), .rx_q(rx_q));
	// ----
	// tasks
	// ----
	// an answer arrives one frame late, so each frame carries the older note
	task automatic op(input logic [15:0] cmd);
		notes.push_back(pend);
		pend = 17'h00000;
		i_host.frame(cmd);
	endtask
	task automatic rd(input logic [6:0] a, input logic [15:0] e);
		op({1'b0, a, 8'h00});
		pend = {1'b1, e};
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		op({1'b1, a, d});
	endtask
	task automatic kick();
		@(negedge clock);
		capture_start = 1'b1;
		@(negedge clock);
		capture_start = 1'b0;
	endtask
	task automatic idle_wait();
		for (int i = 0; i < 30000 && (capture_busy | autonull_busy) !== 1'b0; i++)
			@(negedge clock);
	endtask
	// random gaps stall the engine side; words of the other kind are dropped
	task automatic feed(input int n, input logic cst);
		int   k;
		int   r;
		logic take;
		k = 0;
		while (k < n) begin
			@(negedge clock);
			r = $random(seed);
			smp_valid = cst | r[4];
			smp_is_vel = ~cst & r[3];
			smp_x = cst ? 16'h0100 : r[15:0];
			smp_y = cst ? 16'hff00 : r[31:16];
			smp_z = ~r[15:0];
			smp_rss = r[23:8];
			take = smp_valid && smp_ready && (smp_is_vel == velocity_en);
			if (take) begin
				mx[k] = smp_x + ((rec_mode == VBR_MODE_TIME) ? ofs_x : 16'h0000);
				my[k] = smp_y + ((rec_mode == VBR_MODE_TIME) ? ofs_y : 16'h0000);
				mz[k] = rss_en ? smp_rss : smp_z;
				k++;
			end
		end
		@(negedge clock);
		smp_valid = 1'b0;
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ----
	// answer monitor and watchdog
	// ----
	always @(posedge clock) begin
		if (rx_stb === 1'b1) begin
			nt = notes.pop_front();
			if (nt[16] === 1'b1) begin
				check_count++;
				if (rx_q !== nt[15:0]) begin
					$display("[FAIL] serial answer expected %h seen %h", nt[15:0], rx_q);
					n_mismatch++;
				end
			end
		end
	end
	initial begin
		#3000000;
		n_mismatch++;
		close_out();
	end
	// ----
	// main sequence
	// ----
	initial begin
		seed = 23;
		{arst_n, velocity_en, rss_en, capture_start, smp_valid, smp_is_vel} = 6'h00;
		{smp_x, smp_y, smp_z, smp_rss, ofs_x, ofs_y} = 96'h0;
		restore_valid = 1'b0;
		restore_x = $random(seed);
		restore_y = $random(seed);
		rec_mode = VBR_MODE_MSPEC;
		pend = 17'h00000;
		repeat (8) @(negedge clock);
		arst_n = 1'b1;
		repeat (3) @(negedge clock);
		rd(7'h14, 16'h0000);
		rd(7'h16, 16'h0000);
		rd(7'h20, 16'h0000);
		wr(7'h10, 8'haa);
		rd(7'h10, 16'h0000);
		wr(7'h3e, 8'h01);
		feed(4096, 1'b1);
		idle_wait();
		rd(7'h14, 16'hff00);
		rd(7'h16, 16'h0100);
		$display("reset and auto-null test done");
		wr(7'h14, 8'h64);
		wr(7'h15, 8'h00);
		wr(7'h16, 8'h9c);
		wr(7'h17, 8'hff);
		ofs_x = 16'h0064;
		ofs_y = 16'hff9c;
		rd(7'h14, 16'h0064);
		rd(7'h16, 16'hff9c);
		rec_mode = VBR_MODE_STREAM;
		kick();
		rec_mode = VBR_MODE_TIME;
		rss_en = 1'b1;
		kick();
		rd(7'h0e, 16'h8000);
		wr(7'h7f, 8'h00);
		feed(4096, 1'b0);
		idle_wait();
		rd(7'h0e, mx[0]);
		rd(7'h10, my[1]);
		rd(7'h12, mz[2]);
		wr(7'h0a, 8'hff);
		wr(7'h0b, 8'h0f);
		rd(7'h0e, mx[4095]);
		rd(7'h0e, mx[0]);
		wr(7'h7f, 8'h00);
		$display("time capture test done");
		for (int m = 0; m < 2; m++) begin
			rec_mode = vbr_mode_e'(m);
			velocity_en = 1'b1;
			rss_en = 1'b0;
			kick();
			feed(2048, 1'b0);
			idle_wait();
			rd(7'h12, mz[0]);
			rd(7'h0e, mx[1]);
			wr(7'h0a, 8'hff);
			wr(7'h0b, 8'h07);
			rd(7'h10, my[2047]);
			rd(7'h10, my[0]);
			wr(7'h7f, 8'h00);
		end
		$display("spectral capture test done");
		restore_valid = 1'b1;
		arst_n = 1'b0;
		repeat (8) @(negedge clock);
		arst_n = 1'b1;
		repeat (3) @(negedge clock);
		rd(7'h14, restore_x);
		rd(7'h16, restore_y);
		wr(7'h7f, 8'h00);
		$display("restore test done");
		close_out();
	end
endmodule // vbr_readout_tb_top
`default_nettype wire
